// File: rtl/swl_framer.sv
// card-side framer of the single-wire link: bits, flags, check, LLC
`timescale 1ns/1ps
`default_nettype none
// How it works
// - bytes travel most significant bit first
// - frames open with 7E, close with 7F
// - zero idle bits, at least one between frames
// - card sends one wakeup one before frames
// - suspend during wakeup bit becomes slave resume
// - payload never longer than thirty bytes
// - sixteen-bit check, preset all ones, verified
// - check covers bits between flags only
// - stuff zero after five ones, not final
// - receiver drops the stuffed zeros
// - first payload byte selects the LLC
// - activation or voltage rise restores activation LLC
// - no activation frames once link is up
// - raw session keeps reliable link context
// - reliable frame during raw session closes it
// - corrupt frame uses last good frame's LLC
// - card sends FR zero, ignores received CAPABILITY_PRESENT_FLAG
// - code 000 ready, 001 sync with identity
// - reserved codes and capability bits never sent
// - capability bits two to zero kept
// - first non-activation frame without power: low
module swl_framer
  import swl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_last_in,
  output logic            tx_ready_out,
  input  wire logic       link_bit_take_in,
  output logic            tx_bit_out,
  output logic            tx_frame_out,
  input  wire logic       suspend_start_in,
  output logic            slave_resume_out,
  input  wire logic       link_bit_in,
  input  wire logic       link_bit_valid_in,
  input  wire logic       link_reactivate_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_last_out,
  input  wire logic       rx_ready_in,
  output logic            rx_error_out,
  output swl_llc_t        error_llc_out,
  output logic            rx_overrun_out,
  output swl_llc_t        llc_out,
  output logic            power_low_out,
  output logic            power_full_out
);
  typedef enum logic [2:0] {
    TX_LOAD, TX_WAKE, TX_SOF, TX_DATA, TX_CRC, TX_EOF
  } swl_tx_t;

  typedef struct packed {
    swl_tx_t                          tst;
    logic [SWL_MAX_PAYLOAD-1:0][7:0]  tmem;
    logic [SWL_RX_DEPTH-1:0][7:0]     rmem;
    logic [5:0]                       tlen, tidx, rcnt, ridx, rlen;
    logic [3:0]                       tcnt;
    logic [7:0]                       tsh, rsh;
    logic [2:0]                       tones, rones, rbits;
    logic [15:0]                      tcrc, rcrc, rchk;
    logic                             tgo, tidle, tstuff, tbit;
    logic                             tframe, tready, resume;
    logic                             rin, rflag, rlong, rdrain;
    logic                             err, ovr, pm_seen;
    swl_llc_t                         llc, last, err_llc;
    swl_power_t                       pwr;
    swl_word_t                        q0, q1;
  } swl_state_t;

  swl_state_t s_q;
  swl_state_t s_d;

  always_comb begin
    logic       b;
    logic [7:0] fb;
    swl_llc_t   fl;
    swl_word_t  w;
    b = link_bit_in;
    fb = s_q.tmem[0];
    fl = swl_llc_of(fb);
    w = '0;
    s_d = s_q;
    s_d.resume = suspend_start_in && s_q.tst == TX_WAKE;
    s_d.err = 1'b0;
    s_d.ovr = 1'b0;
    // transmit side: collect a whole frame, then serialise it
    if (tx_valid_in && s_q.tready) begin
      if (s_q.tlen < SWL_TX_MAX) begin
        s_d.tmem[s_q.tlen[4:0]] = tx_data_in;
        s_d.tlen = s_q.tlen + 6'h01;
      end
      s_d.tgo = tx_last_in;
    end
    if (link_bit_take_in) begin
      unique case (s_q.tst)
        TX_LOAD: begin
          s_d.tidle = 1'b1;
          s_d.tbit = 1'b0;
          if (s_q.tgo && s_q.tidle) begin
            if (s_q.tlen == '0 || fl == SWL_RESERVED ||
                (fl == SWL_ACT && (s_q.llc != SWL_ACT ||
                 fb[SWL_CTRL_MSB:0] > SWL_CTRL_POWER))) begin
              s_d.tgo = 1'b0;
              s_d.tlen = '0;
            end else begin
              if (fl == SWL_ACT) begin
                s_d.tmem[0][SWL_FR_BIT] = 1'b0;
                if (fb[SWL_INF_BIT] && s_q.tlen > 6'h01)
                  s_d.tmem[s_q.tlen[4:0] - 5'h01] =
                    s_q.tmem[s_q.tlen[4:0] - 5'h01] & SWL_CAP_KEEP;
              end
              s_d.tst = TX_WAKE;
              s_d.tbit = 1'b1;
              s_d.tframe = 1'b1;
            end
          end
        end
        TX_WAKE: begin
          s_d.tst = TX_SOF;
          s_d.tsh = SWL_START_FLAG;
          s_d.tcnt = '0;
          s_d.tbit = SWL_START_FLAG[7];
        end
        TX_SOF, TX_EOF: begin
          s_d.tsh = {s_q.tsh[6:0], 1'b0};
          s_d.tcnt = s_q.tcnt + 4'h1;
          s_d.tbit = s_d.tsh[7];
          if (s_q.tcnt == SWL_BYTE_LAST && s_q.tst == TX_SOF) begin
            s_d.tst = TX_DATA;
            s_d.tidx = '0;
            s_d.tcnt = '0;
            s_d.tones = '0;
            s_d.tsh = s_q.tmem[0];
            s_d.tcrc = SWL_CRC_PRESET;
            s_d.tbit = s_q.tmem[0][7];
          end else if (s_q.tcnt == SWL_BYTE_LAST) begin
            s_d.tst = TX_LOAD;
            s_d.tframe = 1'b0;
            s_d.tidle = 1'b0;
            s_d.tgo = 1'b0;
            s_d.tlen = '0;
            s_d.tbit = 1'b0;
          end
        end
        TX_DATA, TX_CRC: begin
          if (s_q.tstuff) begin
            s_d.tstuff = 1'b0;
            s_d.tones = '0;
            s_d.tbit = (s_q.tst == TX_DATA) ? s_q.tsh[7] : s_q.tcrc[15];
          end else begin
            s_d.tones = s_q.tbit ? s_q.tones + 3'h1 : '0;
            s_d.tcnt = s_q.tcnt + 4'h1;
            if (s_q.tst == TX_DATA) begin
              s_d.tcrc = swl_crc_step(s_q.tcrc, s_q.tbit);
              s_d.tsh = {s_q.tsh[6:0], 1'b0};
              if (s_q.tcnt == SWL_BYTE_LAST) begin
                s_d.tcnt = '0;
                s_d.tidx = s_q.tidx + 6'h01;
                if (s_d.tidx == s_q.tlen)
                  s_d.tst = TX_CRC;
                else
                  s_d.tsh = s_q.tmem[s_d.tidx[4:0]];
              end
              s_d.tbit = (s_d.tst == TX_DATA) ? s_d.tsh[7] : s_d.tcrc[15];
            end else if (s_q.tcnt == SWL_CRC_LAST) begin
              s_d.tst = TX_EOF;
              s_d.tsh = SWL_END_FLAG;
              s_d.tcnt = '0;
              s_d.tbit = SWL_END_FLAG[7];
            end else begin
              s_d.tcrc = {s_q.tcrc[14:0], 1'b0};
              s_d.tbit = s_d.tcrc[15];
            end
            // the final check bit is never followed by a stuffed zero
            if (s_d.tst != TX_EOF && s_d.tones == SWL_STUFF_RUN) begin
              s_d.tstuff = 1'b1;
              s_d.tbit = 1'b0;
            end
          end
        end
      endcase
    end
    s_d.tready = s_d.tst == TX_LOAD && !s_d.tgo;
    // receive side: six ones announce a flag, the next bit tells which
    if (link_bit_valid_in) begin
      if (s_q.rflag) begin
        s_d.rflag = 1'b0;
        s_d.rones = '0;
        if (!b) begin
          // a frame arriving while the last one drains is lost
          s_d.rin = !s_q.rdrain;
          s_d.ovr = s_q.rdrain;
          s_d.rcnt = '0;
          s_d.rbits = '0;
          s_d.rlong = 1'b0;
          s_d.rcrc = SWL_CRC_PRESET;
          s_d.rchk = SWL_CRC_PRESET;
        end else if (s_q.rin) begin
          s_d.rin = 1'b0;
          fb = s_q.rmem[0];
          fl = swl_llc_of(fb);
          if (s_q.rlong || s_q.rcnt <= SWL_RX_CRC ||
              s_q.rchk != '0) begin
            s_d.err = 1'b1;
            s_d.err_llc = s_q.last;
          end else begin
            s_d.ridx = '0;
            s_d.rlen = s_q.rcnt - SWL_RX_CRC;
            unique case (fl)
              SWL_RELIABLE, SWL_RAW: begin
                // raw entry clears nothing, so reliable state survives
                s_d.llc = fl;
                s_d.last = fl;
                s_d.rdrain = 1'b1;
                if (!s_q.pm_seen) begin
                  s_d.pm_seen = 1'b1;
                  s_d.pwr.low = 1'b1;
                end
              end
              SWL_ACT: begin
                // received CAPABILITY_PRESENT_FLAG is never looked at
                if (s_q.llc == SWL_ACT) begin
                  s_d.last = SWL_ACT;
                  s_d.rdrain = 1'b1;
                  if (fb[SWL_CTRL_MSB:0] == SWL_CTRL_POWER &&
                      s_q.rcnt > SWL_RX_CRC + 6'h01 && !s_q.pm_seen) begin
                    s_d.pm_seen = 1'b1;
                    s_d.pwr.low = s_q.rmem[1] == SWL_PWR_LOW;
                    s_d.pwr.full = s_q.rmem[1] == SWL_PWR_FULL;
                  end
                end
              end
              SWL_RESERVED: begin
              end
            endcase
          end
        end
      end else if (s_q.rones == SWL_STUFF_RUN) begin
        s_d.rflag = b;
        s_d.rones = '0;
      end else begin
        s_d.rones = b ? s_q.rones + 3'h1 : '0;
        if (s_q.rin) begin
          s_d.rsh = {s_q.rsh[6:0], b};
          s_d.rcrc = swl_crc_step(s_q.rcrc, b);
          s_d.rbits = s_q.rbits + 3'h1;
          // snapshot at byte edges keeps the closing flag out
          if (s_q.rbits == SWL_RX_BIT_LAST) begin
            s_d.rchk = s_d.rcrc;
            if (s_q.rcnt == SWL_RX_FULL) begin
              s_d.rlong = 1'b1;
            end else begin
              s_d.rmem[s_q.rcnt[4:0]] = s_d.rsh;
              s_d.rcnt = s_q.rcnt + 6'h01;
            end
          end
        end
      end
    end
    if (link_reactivate_in) begin
      s_d.llc = SWL_ACT;
      s_d.last = SWL_ACT;
    end
    // two-entry output buffer: pop first, then fill lowest free slot
    if (rx_ready_in && s_q.q0.valid) begin
      s_d.q0 = s_q.q1;
      s_d.q1.valid = 1'b0;
    end
    if (s_q.rdrain && !s_q.q1.valid) begin
      w.data = s_q.rmem[s_q.ridx[4:0]];
      w.last = s_q.ridx == s_q.rlen - 6'h01;
      w.valid = 1'b1;
      if (!s_d.q0.valid)
        s_d.q0 = w;
      else
        s_d.q1 = w;
      s_d.ridx = s_q.ridx + 6'h01;
      s_d.rdrain = !w.last;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tx_ready_out     = s_q.tready;
  assign tx_bit_out       = s_q.tbit;
  assign tx_frame_out     = s_q.tframe;
  assign slave_resume_out = s_q.resume;
  assign rx_data_out      = s_q.q0.data;
  assign rx_valid_out     = s_q.q0.valid;
  assign rx_last_out      = s_q.q0.last;
  assign rx_error_out     = s_q.err;
  assign error_llc_out    = s_q.err_llc;
  assign rx_overrun_out   = s_q.ovr;
  assign llc_out          = s_q.llc;
  assign power_low_out    = s_q.pwr.low;
  assign power_full_out   = s_q.pwr.full;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence take_wake;
    link_bit_take_in && s_q.tst == TX_WAKE;
  endsequence
  sequence fifth_one;
    link_bit_take_in && !s_q.tstuff && s_q.tbit &&
    s_q.tones == SWL_STUFF_RUN - 3'h1 &&
    (s_q.tst == TX_DATA ||
     (s_q.tst == TX_CRC && s_q.tcnt != SWL_CRC_LAST));
  endsequence
  sequence rx_end;
    link_bit_valid_in && s_q.rflag && link_bit_in && s_q.rin;
  endsequence

  chk_wake_bit:
    assert property ($rose(tx_frame_out) |-> tx_bit_out)
    else $error("frame did not open with a wakeup one");
  chk_idle_gap:
    assert property ($rose(tx_frame_out) |-> $past(s_q.tidle))
    else $error("frame started without an idle bit");
  chk_idle_zero:
    assert property (!tx_frame_out |-> !tx_bit_out)
    else $error("idle bit was not zero");
  chk_start_flag:
    assert property (take_wake |=> s_q.tsh == SWL_START_FLAG ##0
                     tx_bit_out == SWL_START_FLAG[7])
    else $error("start flag did not follow the wakeup bit");
  chk_msb_order:
    assert property (link_bit_take_in && s_q.tst == TX_SOF &&
                     s_q.tcnt != SWL_BYTE_LAST |=>
                     tx_bit_out == $past(s_q.tsh[6]))
    else $error("flag bits left out of order");
  chk_stuff_zero:
    assert property (fifth_one |=> s_q.tstuff && !tx_bit_out)
    else $error("no zero after five ones");
  chk_slave_resume:
    assert property (suspend_start_in && s_q.tst == TX_WAKE |=>
                     slave_resume_out)
    else $error("suspend during wakeup gave no resume");
  chk_good_check:
    assert property ($rose(s_q.rdrain) |-> s_q.rchk == '0 &&
                     s_q.rlen <= SWL_TX_MAX)
    else $error("bad or oversize frame was handed on");
  chk_act_ignored:
    assert property (rx_end ##0 swl_llc_of(s_q.rmem[0]) == SWL_ACT &&
                     s_q.llc != SWL_ACT |=> !s_q.rdrain)
    else $error("activation frame taken after link setup");
  chk_err_llc:
    assert property (rx_error_out |-> error_llc_out == $past(s_q.last))
    else $error("error reported against the wrong LLC");
  chk_reactivate:
    assert property (link_reactivate_in |=> llc_out == SWL_ACT)
    else $error("reactivation kept a stale LLC");
  chk_tx_length:
    assert property (s_q.tlen <= SWL_TX_MAX)
    else $error("transmit payload above the limit");
endmodule // swl_framer
`default_nettype wire

// File: rtl/swl_pkg.sv
// constants, carrier types and shared decoders of the single-wire framer
package swl_pkg;
  localparam logic [7:0]  SWL_START_FLAG  = 8'h7E;
  localparam logic [7:0]  SWL_END_FLAG    = 8'h7F;
  localparam logic [15:0] SWL_CRC_POLY    = 16'h1021;
  localparam logic [15:0] SWL_CRC_PRESET  = 16'hFFFF;
  localparam int          SWL_MAX_PAYLOAD = 30;
  localparam int          SWL_CRC_BYTES   = 2;
  localparam int          SWL_RX_DEPTH    = SWL_MAX_PAYLOAD + SWL_CRC_BYTES;
  localparam logic [5:0]  SWL_TX_MAX      = 6'(SWL_MAX_PAYLOAD);
  localparam logic [5:0]  SWL_RX_FULL     = 6'(SWL_RX_DEPTH);
  localparam logic [5:0]  SWL_RX_CRC      = 6'(SWL_CRC_BYTES);
  localparam logic [3:0]  SWL_BYTE_LAST   = 4'h7;
  localparam logic [3:0]  SWL_CRC_LAST    = 4'hF;
  localparam logic [2:0]  SWL_RX_BIT_LAST = 3'h7;
  localparam logic [2:0]  SWL_STUFF_RUN   = 3'h5;
  localparam int          SWL_LLC_MSB     = 7;
  localparam int          SWL_LLC_LSB     = 5;
  localparam logic [2:0]  SWL_LLC_ACT     = 3'h3;
  localparam logic [2:0]  SWL_LLC_RAW     = 3'h2;
  localparam int          SWL_FR_BIT      = 4;
  localparam int          SWL_INF_BIT     = 3;
  localparam int          SWL_CTRL_MSB    = 2;
  localparam logic [2:0]  SWL_CTRL_READY  = 3'h0;
  localparam logic [2:0]  SWL_CTRL_SYNC   = 3'h1;
  localparam logic [2:0]  SWL_CTRL_POWER  = 3'h2;
  localparam logic [7:0]  SWL_PWR_LOW     = 8'h00;
  localparam logic [7:0]  SWL_PWR_FULL    = 8'h01;
  localparam logic [7:0]  SWL_CAP_KEEP    = 8'h07;

  typedef enum logic [1:0] {
    SWL_ACT, SWL_RELIABLE, SWL_RAW, SWL_RESERVED
  } swl_llc_t;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       valid;
  } swl_word_t;
  typedef struct packed {
    logic low;
    logic full;
  } swl_power_t;

  function automatic logic [15:0] swl_crc_step(logic [15:0] c, logic b);
    return (c[15] ^ b) ? ({c[14:0], 1'b0} ^ SWL_CRC_POLY)
                       : {c[14:0], 1'b0};
  endfunction

  function automatic swl_llc_t swl_llc_of(logic [7:0] b);
    if (b[SWL_LLC_MSB])
      return SWL_RELIABLE;
    if (b[SWL_LLC_MSB:SWL_LLC_LSB] == SWL_LLC_ACT)
      return SWL_ACT;
    if (b[SWL_LLC_MSB:SWL_LLC_LSB] == SWL_LLC_RAW)
      return SWL_RAW;
    return SWL_RESERVED;
  endfunction
endpackage

// File: test/swl_fe_model.sv
// front-end link master model: sends frames bit by bit and collects them
`timescale 1ns/1ps
`default_nettype none
module swl_fe_model
  import swl_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic tx_bit_in,
  input  wire logic tx_frame_in,
  output logic      bit_out,
  output logic      bit_valid_out,
  output logic      take_out
);
  initial begin
    bit_out = 1'b0;
    bit_valid_out = 1'b0;
    take_out = 1'b0;
  end

  function automatic logic [15:0] crc_of(input bit b[$]);
    logic [15:0] c;
    c = SWL_CRC_PRESET;
    foreach (b[i])
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? SWL_CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic send_frame(input logic [7:0] pl[$], input bit bad);
    bit body[$];
    bit w[$];
    logic [15:0] c;
    int ones;
    foreach (pl[i])
      for (int k = 7; k >= 0; k--)
        body.push_back(pl[i][k]);
    c = crc_of(body) ^ {15'h0000, bad};
    for (int k = 15; k >= 0; k--)
      body.push_back(c[k]);
    for (int k = 7; k >= 0; k--)
      w.push_back(SWL_START_FLAG[k]);
    ones = 0;
    foreach (body[i]) begin
      w.push_back(body[i]);
      ones = body[i] ? ones + 1 : 0;
      if (ones == 5 && i != body.size() - 1) begin
        w.push_back(1'b0);
        ones = 0;
      end
    end
    for (int k = 7; k >= 0; k--)
      w.push_back(SWL_END_FLAG[k]);
    w.push_back(1'b0);
    w.push_back(1'b0);
    foreach (w[i]) begin
      @(posedge clk_in) #1;
      bit_out = w[i];
      bit_valid_out = 1'b1;
      @(posedge clk_in) #1;
      bit_valid_out = 1'b0;
      // line is not driven between bits, so show junk
      bit_out = !w[i];
    end
  endtask

  task automatic take_one(output bit b, output bit f);
    @(posedge clk_in) #1;
    take_out = 1'b1;
    b = tx_bit_in;
    f = tx_frame_in;
    @(posedge clk_in) #1;
    take_out = 1'b0;
  endtask

  task automatic get_frame(output logic [7:0] q[$], output bit ok,
                           input int lim);
    bit w[$];
    bit d[$];
    bit b;
    bit f;
    int idle;
    int ones;
    logic [7:0] y;
    q = {};
    idle = 0;
    for (int k = 0; k < lim; k++) begin
      take_one(b, f);
      if (f)
        w.push_back(b);
      else if (w.size() > 0)
        break;
      else
        idle++;
    end
    ok = w.size() > 17 && w[0] && idle > 0;
    if (!ok)
      return;
    for (int k = 0; k < 8; k++)
      ok = ok && w[1+k] == SWL_START_FLAG[7-k]
              && w[w.size()-8+k] == SWL_END_FLAG[7-k];
    ones = 0;
    for (int i = 9; i < w.size() - 8; i++) begin
      if (ones == 5) begin
        ok = ok && !w[i];
        ones = 0;
      end else begin
        d.push_back(w[i]);
        ones = w[i] ? ones + 1 : 0;
      end
    end
    ok = ok && d.size() % 8 == 0 && crc_of(d) == 16'h0000;
    for (int i = 0; i + 16 < d.size(); i++) begin
      y = {y[6:0], d[i]};
      if (i % 8 == 7)
        q.push_back(y);
    end
  endtask
endmodule // swl_fe_model
`default_nettype wire

// File: test/swl_framer_tb.sv
// self-checking bench for the card-side single-wire framer
`timescale 1ns/1ps
`default_nettype none
module swl_framer_tb;
  import swl_pkg::*;
  typedef struct {
    int         n;
    logic [7:0] d [4];
    logic [7:0] e [4];
    swl_llc_t   llc;
  } swl_row_t;
  logic       clk_in, reset_in, tx_valid_in, tx_last_in, tx_ready_out;
  logic       link_bit_take_in, tx_bit_out, tx_frame_out, suspend_start_in;
  logic       slave_resume_out, link_bit_in, link_bit_valid_in;
  logic       link_reactivate_in, rx_valid_out, rx_last_out, rx_ready_in;
  logic       rx_error_out, rx_overrun_out, power_low_out, power_full_out;
  logic [7:0] tx_data_in, rx_data_out;
  swl_llc_t   error_llc_out, llc_out, err_llc;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         err_seen = 0;
  int         ovr_seen = 0;
  // power frame first, then capability reshaping, raw, reliable, raw
  swl_row_t   rows [5] = '{
    '{2,'{8'h62,8'h01,8'h00,8'h00},'{8'h62,8'h01,8'h00,8'h00},SWL_ACT},
    '{4,'{8'h79,8'hA5,8'hB6,8'hFF},'{8'h69,8'hA5,8'hB6,8'h07},SWL_ACT},
    '{3,'{8'h40,8'hFF,8'hF8,8'h00},'{8'h40,8'hFF,8'hF8,8'h00},SWL_RAW},
    '{3,'{8'hFF,8'h7E,8'h7F,8'h00},'{8'hFF,8'h7E,8'h7F,8'h00},SWL_RELIABLE},
    '{2,'{8'h5F,8'hFF,8'h00,8'h00},'{8'h5F,8'hFF,8'h00,8'h00},SWL_RAW}};

  swl_framer dut (
    .clk_in, .reset_in, .tx_data_in, .tx_valid_in, .tx_last_in,
    .tx_ready_out, .link_bit_take_in, .tx_bit_out, .tx_frame_out,
    .suspend_start_in, .slave_resume_out, .link_bit_in, .link_bit_valid_in,
    .link_reactivate_in, .rx_data_out, .rx_valid_out, .rx_last_out,
    .rx_ready_in, .rx_error_out, .error_llc_out, .rx_overrun_out, .llc_out,
    .power_low_out, .power_full_out);
  swl_fe_model fe (
    .clk_in, .tx_bit_in(tx_bit_out), .tx_frame_in(tx_frame_out),
    .bit_out(link_bit_in), .bit_valid_out(link_bit_valid_in),
    .take_out(link_bit_take_in));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic send_tx(input logic [7:0] q[$]);
    foreach (q[i]) begin
      tx_data_in = q[i];
      tx_valid_in = 1'b1;
      tx_last_in = i == q.size() - 1;
      for (int k = 0; k < 200 && tx_ready_out !== 1'b1; k++)
        tick(1);
      chk(tx_ready_out, 1'b1);
      tick(1);
    end
    tx_valid_in = 1'b0;
    tx_last_in = 1'b0;
  endtask

  // one byte per two cycles: the consumer stalls between bytes
  task automatic get_rx(output logic [7:0] q[$]);
    bit last;
    q = {};
    for (int k = 0; k < 400; k++) begin
      if (rx_valid_out === 1'b1) begin
        q.push_back(rx_data_out);
        last = rx_last_out;
        rx_ready_in = 1'b1;
        tick(1);
        rx_ready_in = 1'b0;
        if (last)
          break;
      end
      tick(1);
    end
    chk(last, 1'b1);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = !clk_in;
  end

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rx_error_out === 1'b1) begin
      err_seen <= err_seen + 1;
      err_llc <= error_llc_out;
    end
    if (rx_overrun_out === 1'b1)
      ovr_seen <= ovr_seen + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    logic [7:0] q[$];
    logic [7:0] g[$];
    bit ok;
    bit b;
    bit f;
    {tx_data_in, tx_valid_in, tx_last_in, suspend_start_in} = '0;
    {link_reactivate_in, rx_ready_in} = '0;
    err_llc = SWL_ACT;
    reset_in = 1'b1;
    tick(3);
    chk({tx_ready_out, rx_valid_out, tx_frame_out, tx_bit_out}, 4'h0);
    chk({power_low_out, power_full_out, llc_out}, 4'h0);
    reset_in = 1'b0;
    tick(2);
    foreach (rows[r]) begin
      q = {};
      for (int i = 0; i < rows[r].n; i++)
        q.push_back(rows[r].d[i]);
      fe.send_frame(q, 1'b0);
      get_rx(g);
      chk(g.size(), rows[r].n);
      foreach (g[i])
        chk(g[i], rows[r].d[i]);
      chk(llc_out, rows[r].llc);
      chk({power_low_out, power_full_out}, 2'b01);
      send_tx(q);
      fe.get_frame(g, ok, 2000);
      chk({ok, g.size() == rows[r].n}, 2'b11);
      foreach (g[i])
        chk(g[i], rows[r].e[i]);
      $display("test row %0d done", r);
    end
    // second frame lands while the stalled first one still drains
    q = {8'h40, 8'h01, 8'h02, 8'h03, 8'h04};
    fe.send_frame(q, 1'b0);
    q = {8'h40, 8'h33};
    fe.send_frame(q, 1'b0);
    chk(ovr_seen, 1);
    get_rx(g);
    chk({g.size() == 5, g[4]}, {1'b1, 8'h04});
    q = {8'h40, 8'h11};
    fe.send_frame(q, 1'b1);
    chk(err_seen, 1);
    chk(err_llc, SWL_RAW);
    q = {};
    repeat (31) q.push_back(8'h40);
    fe.send_frame(q, 1'b0);
    chk(err_seen, 2);
    q = {8'h60};
    fe.send_frame(q, 1'b0);
    q = {8'h1F, 8'h00};
    fe.send_frame(q, 1'b0);
    chk({rx_valid_out, llc_out}, {1'b0, SWL_RAW});
    chk(err_seen, 2);
    $display("test rx refusals done");
    q = {8'h40};
    repeat (31) q.push_back(8'h5A);
    send_tx(q);
    fe.get_frame(g, ok, 2000);
    chk({ok, g.size() == 30, g[29]}, {2'b11, 8'h5A});
    q = {8'h60};
    send_tx(q);
    fe.get_frame(g, ok, 200);
    chk(g.size(), 0);
    q = {8'h1F};
    send_tx(q);
    fe.get_frame(g, ok, 200);
    chk(g.size(), 0);
    link_reactivate_in = 1'b1;
    tick(1);
    link_reactivate_in = 1'b0;
    tick(1);
    chk(llc_out, SWL_ACT);
    q = {8'h60};
    fe.send_frame(q, 1'b1);
    chk(err_seen, 3);
    chk(err_llc, SWL_ACT);
    q = {8'h63};
    send_tx(q);
    fe.get_frame(g, ok, 200);
    chk(g.size(), 0);
    q = {8'h60};
    send_tx(q);
    fe.get_frame(g, ok, 200);
    chk({ok, g.size() == 1, g[0]}, {2'b11, 8'h60});
    $display("test tx refusals done");
    send_tx(q);
    for (int k = 0; k < 40 && tx_frame_out !== 1'b1; k++)
      fe.take_one(b, f);
    chk(tx_bit_out, 1'b1);
    suspend_start_in = 1'b1;
    tick(1);
    chk(slave_resume_out, 1'b1);
    suspend_start_in = 1'b0;
    reset_in = 1'b1;
    tick(3);
    reset_in = 1'b0;
    tick(2);
    q = {8'h40, 8'h22};
    fe.send_frame(q, 1'b0);
    get_rx(g);
    chk({g.size() == 2, g[1]}, {1'b1, 8'h22});
    chk({power_low_out, power_full_out}, 2'b10);
    $display("test resume and low power done");
    summarize();
  end
endmodule // swl_framer_tb
`default_nettype wire
